// ==== design/wfm_pkg.sv ====
// Shared constants and helpers for the wake frame match block
package wfm_pkg;

  // Register offsets on the serial register port
  localparam logic [6:0] WFM_ADDR_MASK_UPPER = 7'h27;
  localparam logic [6:0] WFM_ADDR_MASK_UPPER_MID = 7'h28;
  localparam logic [6:0] WFM_ADDR_MASK_LOWER_MID = 7'h29;
  localparam logic [6:0] WFM_ADDR_MASK_LOWER = 7'h2a;
  localparam logic [6:0] WFM_ADDR_LENGTH_CODE = 7'h2b;
  localparam logic [6:0] WFM_ADDR_PAYLOAD7 = 7'h2c;
  localparam logic [6:0] WFM_ADDR_PAYLOAD6 = 7'h2d;
  localparam logic [6:0] WFM_ADDR_PAYLOAD5 = 7'h2e;
  localparam logic [6:0] WFM_ADDR_PAYLOAD4 = 7'h2f;

  // Reset value of every register in this block
  localparam logic [7:0] WFM_RESET_VALUE = 8'h00;

  // Lowest mask register: identifier mask bits 4..0 live in bits 6:2
  localparam int WFM_MASK_LOWER_LSB = 2;
  localparam int WFM_MASK_LOWER_MSB = 6;
  localparam logic [7:0] WFM_MASK_LOWER_KEEP = 8'h7c;

  // Length code register: only the low nibble exists
  localparam logic [7:0] WFM_LENGTH_CODE_KEEP = 8'h0f;

  // Standard identifiers sit on identifier bits 28 down to 18
  localparam logic [28:0] WFM_STD_ID_WINDOW = 29'h1ffc0000;
  localparam logic [28:0] WFM_EXT_ID_WINDOW = 29'h1fffffff;

  // Length codes of this value and above all mean eight bytes
  localparam logic [3:0] WFM_MAX_PAYLOAD = 4'h8;

  // First payload byte index held by this block
  localparam int WFM_FIRST_HELD_BYTE = 4;

  // Payload length in bytes for a four-bit length code
  function automatic logic [3:0] wfm_payload_len(input logic [3:0] code);
    wfm_payload_len = (code > WFM_MAX_PAYLOAD) ? WFM_MAX_PAYLOAD : code;
  endfunction

endpackage

// ==== design/wfm_frame_compare.sv ====
// Combinational compare of one received frame against the wake configuration
`timescale 1ns/1ns
module wfm_frame_compare
  import wfm_pkg::*;
(
  input wire logic [28:0] cfg_id_mask,
  input wire logic [28:0] cfg_id_value,
  input wire logic cfg_id_ext,
  input wire logic [3:0] cfg_length_code,
  input wire logic [31:0] cfg_payload_hi,
  input wire logic [28:0] rx_id,
  input wire logic rx_id_ext,
  input wire logic [3:0] rx_length_code,
  input wire logic [31:0] rx_payload_hi,
  input wire logic rx_low_bytes_match,
  output logic id_ok,
  output logic length_ok,
  output logic payload_ok,
  output logic match
);

  // Mask narrowed to the identifier window of the configured format
  logic [28:0] eff_mask;
  // Number of payload bytes the received length code announces
  logic [3:0] rx_len;

  // Identifier: only bits with a mask of one are compared
  always_comb begin
    eff_mask = cfg_id_mask & (cfg_id_ext ? WFM_EXT_ID_WINDOW : WFM_STD_ID_WINDOW);
    id_ok = (((rx_id ^ cfg_id_value) & eff_mask) == 29'h0) && (rx_id_ext == cfg_id_ext);
  end

  // Length code must agree bit for bit, not merely in meaning
  always_comb begin
    length_ok = (rx_length_code == cfg_length_code);
  end

  // Bytes 7..4: byte k counts only if the length reaches past it
  always_comb begin
    rx_len = wfm_payload_len(rx_length_code);
    payload_ok = 1'b1;
    for (int k = 0; k < 4; k++) begin
      if (rx_len > 4'(WFM_FIRST_HELD_BYTE + k)) begin
        if (rx_payload_hi[8*k +: 8] != cfg_payload_hi[8*k +: 8]) begin
          payload_ok = 1'b0;
        end
      end
    end
  end

  // All parts together, lower bytes judged outside this block
  always_comb begin
    match = id_ok && length_ok && payload_ok && rx_low_bytes_match;
  end

endmodule

// ==== design/wfm_core.sv ====
// Wake frame match registers, valid flag and frame compare
// Notes on behaviour
// - Mask one compares identifier bit, zero ignores
// - Mask bits packed 28..21,20..13,12..5, 4..0 at 6:2
// - Unused mask and length bits read zero
// - Codes zero to seven literal, above mean eight
// - Length code must match bit for bit
// - Payload bytes 7..4 full registers at 0x2c-0x2f
// - Power-on or soft reset clears all registers
// - Restart keeps contents, forcing unused bits zero
// - Valid flag cleared on wake, reset, change
// - Standard format uses identifier bits 28..18
`timescale 1ns/1ns
module wfm_core
  import wfm_pkg::*;
(
  input wire logic clock,
  input wire logic resetn,
  input wire logic soft_reset,
  input wire logic restart,
  input wire logic [6:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic cfg_valid_set,
  input wire logic ext_config_changed,
  input wire logic [28:0] cfg_id_value,
  input wire logic cfg_id_ext,
  input wire logic rx_frame_valid,
  input wire logic [28:0] rx_id,
  input wire logic rx_id_ext,
  input wire logic [3:0] rx_length_code,
  input wire logic [7:0] rx_payload_byte_seven,
  input wire logic [7:0] rx_payload_byte_six,
  input wire logic [7:0] rx_payload_byte_five,
  input wire logic [7:0] rx_payload_byte_four,
  input wire logic rx_low_bytes_match,
  output logic [7:0] reg_rdata,
  output logic reg_hit,
  output logic wake_config_valid,
  output logic frame_match,
  output logic wake_detect
);

  // Identifier mask registers, upper to lower
  logic [7:0] wake_id_mask_upper;
  logic [7:0] wake_id_mask_upper_mid;
  logic [7:0] wake_id_mask_lower_mid;
  logic [7:0] wake_id_mask_lower;
  // Length code register, low nibble only
  logic [7:0] wake_frame_length_code;
  // Payload bytes 7..4
  logic [7:0] wake_payload_byte7;
  logic [7:0] wake_payload_byte6;
  logic [7:0] wake_payload_byte5;
  logic [7:0] wake_payload_byte4;

  // Write that lands on one of this block's registers
  logic config_write;
  // Compare results for the frame on the rx ports
  logic id_ok;
  logic length_ok;
  logic payload_ok;
  logic match;
  // Matching frame while the configuration is valid
  logic wake_hit;
  // Full identifier mask and held payload as flat vectors
  logic [28:0] id_mask_full;
  logic [31:0] cfg_payload_hi;
  logic [31:0] rx_payload_hi;

  // True when the address falls on a register of this block
  function automatic logic wfm_is_mapped(input logic [6:0] addr);
    wfm_is_mapped = (addr >= WFM_ADDR_MASK_UPPER) && (addr <= WFM_ADDR_PAYLOAD4);
  endfunction

  // Any write to this block counts as a configuration change
  assign config_write = reg_wr && wfm_is_mapped(reg_addr);

  // Flatten the four mask registers into identifier bit order
  assign id_mask_full = {wake_id_mask_upper, wake_id_mask_upper_mid, wake_id_mask_lower_mid,
    wake_id_mask_lower[WFM_MASK_LOWER_MSB:WFM_MASK_LOWER_LSB]};
  // Byte 4 in the low lane, byte 7 in the high lane
  assign cfg_payload_hi = {wake_payload_byte7, wake_payload_byte6, wake_payload_byte5,
    wake_payload_byte4};
  assign rx_payload_hi = {rx_payload_byte_seven, rx_payload_byte_six, rx_payload_byte_five,
    rx_payload_byte_four};

  // Frame compare, purely combinational
  wfm_frame_compare u_compare (
    .cfg_id_mask(id_mask_full),
    .cfg_id_value(cfg_id_value),
    .cfg_id_ext(cfg_id_ext),
    .cfg_length_code(wake_frame_length_code[3:0]),
    .cfg_payload_hi(cfg_payload_hi),
    .rx_id(rx_id),
    .rx_id_ext(rx_id_ext),
    .rx_length_code(rx_length_code),
    .rx_payload_hi(rx_payload_hi),
    .rx_low_bytes_match(rx_low_bytes_match),
    .id_ok(id_ok),
    .length_ok(length_ok),
    .payload_ok(payload_ok),
    .match(match)
  );

  // A wake only counts while the host has marked the setup valid
  assign wake_hit = rx_frame_valid && match && wake_config_valid;

  // Identifier mask registers
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      wake_id_mask_upper <= WFM_RESET_VALUE;
      wake_id_mask_upper_mid <= WFM_RESET_VALUE;
      wake_id_mask_lower_mid <= WFM_RESET_VALUE;
      wake_id_mask_lower <= WFM_RESET_VALUE;
    end else if (soft_reset) begin
      // Soft reset behaves like power-on for this block
      wake_id_mask_upper <= WFM_RESET_VALUE;
      wake_id_mask_upper_mid <= WFM_RESET_VALUE;
      wake_id_mask_lower_mid <= WFM_RESET_VALUE;
      wake_id_mask_lower <= WFM_RESET_VALUE;
    end else if (restart) begin
      // Contents survive; unused bits are forced clear
      wake_id_mask_lower <= wake_id_mask_lower & WFM_MASK_LOWER_KEEP;
    end else if (reg_wr) begin
      if (reg_addr == WFM_ADDR_MASK_UPPER) begin
        wake_id_mask_upper <= reg_wdata;
      end else if (reg_addr == WFM_ADDR_MASK_UPPER_MID) begin
        wake_id_mask_upper_mid <= reg_wdata;
      end else if (reg_addr == WFM_ADDR_MASK_LOWER_MID) begin
        wake_id_mask_lower_mid <= reg_wdata;
      end else if (reg_addr == WFM_ADDR_MASK_LOWER) begin
        // Unused bits never get stored, so they cannot read back
        wake_id_mask_lower <= reg_wdata & WFM_MASK_LOWER_KEEP;
      end
    end
  end

  // Length code register
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      wake_frame_length_code <= WFM_RESET_VALUE;
    end else if (soft_reset) begin
      wake_frame_length_code <= WFM_RESET_VALUE;
    end else if (restart) begin
      // Only the low nibble is kept across a restart
      wake_frame_length_code <= wake_frame_length_code & WFM_LENGTH_CODE_KEEP;
    end else if (reg_wr && (reg_addr == WFM_ADDR_LENGTH_CODE)) begin
      // Stored raw; codes above eight are not folded to eight
      wake_frame_length_code <= reg_wdata & WFM_LENGTH_CODE_KEEP;
    end
  end

  // Payload byte registers
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      wake_payload_byte7 <= WFM_RESET_VALUE;
      wake_payload_byte6 <= WFM_RESET_VALUE;
      wake_payload_byte5 <= WFM_RESET_VALUE;
      wake_payload_byte4 <= WFM_RESET_VALUE;
    end else if (soft_reset) begin
      wake_payload_byte7 <= WFM_RESET_VALUE;
      wake_payload_byte6 <= WFM_RESET_VALUE;
      wake_payload_byte5 <= WFM_RESET_VALUE;
      wake_payload_byte4 <= WFM_RESET_VALUE;
    end else if (restart) begin
      // Payload is kept as is across a restart
      wake_payload_byte7 <= wake_payload_byte7;
    end else if (reg_wr) begin
      if (reg_addr == WFM_ADDR_PAYLOAD7) begin
        wake_payload_byte7 <= reg_wdata;
      end else if (reg_addr == WFM_ADDR_PAYLOAD6) begin
        wake_payload_byte6 <= reg_wdata;
      end else if (reg_addr == WFM_ADDR_PAYLOAD5) begin
        wake_payload_byte5 <= reg_wdata;
      end else if (reg_addr == WFM_ADDR_PAYLOAD4) begin
        wake_payload_byte4 <= reg_wdata;
      end
    end
  end

  // Read port: data one cycle after the read strobe
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= WFM_RESET_VALUE;
      reg_hit <= 1'b0;
    end else if (reg_rd) begin
      reg_hit <= wfm_is_mapped(reg_addr);
      if (reg_addr == WFM_ADDR_MASK_UPPER) begin
        reg_rdata <= wake_id_mask_upper;
      end else if (reg_addr == WFM_ADDR_MASK_UPPER_MID) begin
        reg_rdata <= wake_id_mask_upper_mid;
      end else if (reg_addr == WFM_ADDR_MASK_LOWER_MID) begin
        reg_rdata <= wake_id_mask_lower_mid;
      end else if (reg_addr == WFM_ADDR_MASK_LOWER) begin
        reg_rdata <= wake_id_mask_lower & WFM_MASK_LOWER_KEEP;
      end else if (reg_addr == WFM_ADDR_LENGTH_CODE) begin
        reg_rdata <= wake_frame_length_code & WFM_LENGTH_CODE_KEEP;
      end else if (reg_addr == WFM_ADDR_PAYLOAD7) begin
        reg_rdata <= wake_payload_byte7;
      end else if (reg_addr == WFM_ADDR_PAYLOAD6) begin
        reg_rdata <= wake_payload_byte6;
      end else if (reg_addr == WFM_ADDR_PAYLOAD5) begin
        reg_rdata <= wake_payload_byte5;
      end else if (reg_addr == WFM_ADDR_PAYLOAD4) begin
        reg_rdata <= wake_payload_byte4;
      end else begin
        // Other addresses belong to neighbouring blocks
        reg_rdata <= WFM_RESET_VALUE;
      end
    end
  end

  // Configuration valid flag
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      wake_config_valid <= 1'b0;
    end else if (soft_reset) begin
      wake_config_valid <= 1'b0;
    end else if (config_write || ext_config_changed || wake_hit) begin
      // Clear wins: a stale setup must never stay armed
      wake_config_valid <= 1'b0;
    end else if (cfg_valid_set) begin
      // Host marks the setup valid after writing it
      wake_config_valid <= 1'b1;
    end
  end

  // Registered match and wake pulses
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      frame_match <= 1'b0;
      wake_detect <= 1'b0;
    end else begin
      frame_match <= rx_frame_valid && match;
      wake_detect <= wake_hit;
    end
  end

  // Checks on the logic above
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  // Register write and read strobes with their address
  sequence seq_write(logic [6:0] a);
    reg_wr && !reg_rd && !soft_reset && !restart && (reg_addr == a);
  endsequence
  sequence seq_read(logic [6:0] a);
    reg_rd && (reg_addr == a);
  endsequence

  AST_MASK_COMPARE: assert property (
    frame_match |-> $past((((rx_id ^ cfg_id_value) & id_mask_full) &
      (cfg_id_ext ? WFM_EXT_ID_WINDOW : WFM_STD_ID_WINDOW)) == 29'h0))
    else $error("Frame matched with a compared identifier bit differing");

  AST_MASK_LOWER_LAYOUT: assert property (
    seq_write(WFM_ADDR_MASK_LOWER) ##1 seq_read(WFM_ADDR_MASK_LOWER) ##0 (!reg_wr && !restart)
      |=> reg_rdata == ($past(reg_wdata, 2) & WFM_MASK_LOWER_KEEP))
    else $error("Lowest mask register did not hold bits 6:2");

  AST_RESERVED_ZERO: assert property (
    reg_hit && $past(reg_rd && (reg_addr == WFM_ADDR_LENGTH_CODE)) |-> reg_rdata[7:4] == 4'h0)
    else $error("Length code upper nibble read non-zero");

  AST_EIGHT_BYTE_CODE: assert property (
    rx_frame_valid && id_ok && length_ok && rx_low_bytes_match &&
      (rx_length_code >= WFM_MAX_PAYLOAD) && (rx_payload_hi == cfg_payload_hi) |=> frame_match)
    else $error("Long length code frame failed to match");

  AST_LENGTH_EXACT: assert property (
    rx_frame_valid && (rx_length_code != wake_frame_length_code[3:0]) |=> !frame_match)
    else $error("Frame matched with a different length code");

  AST_PAYLOAD_READBACK: assert property (
    seq_write(WFM_ADDR_PAYLOAD7) ##1 seq_read(WFM_ADDR_PAYLOAD7) ##0 (!reg_wr && !restart)
      |=> reg_hit && reg_rdata == $past(reg_wdata, 2))
    else $error("Payload byte seven did not read back");

  AST_SOFT_CLEAR: assert property (
    soft_reset |=> (id_mask_full == 29'h0) && (cfg_payload_hi == 32'h0) &&
      (wake_frame_length_code == WFM_RESET_VALUE) && !wake_config_valid)
    else $error("Soft reset left a register set");

  AST_RESTART_KEEP: assert property (
    restart && !soft_reset |=> $stable(cfg_payload_hi) && $stable(id_mask_full) &&
      wake_frame_length_code[7:4] == 4'h0)
    else $error("Restart altered kept contents");

  AST_VALID_CLEAR: assert property (
    (config_write || ext_config_changed || wake_hit) |=> !wake_config_valid ##1
      (!wake_config_valid || $past(cfg_valid_set)))
    else $error("Valid flag survived a change or wake");

  AST_STD_WINDOW: assert property (
    rx_frame_valid && !cfg_id_ext && !rx_id_ext &&
      ((((rx_id ^ cfg_id_value) & id_mask_full) & WFM_STD_ID_WINDOW) == 29'h0) |-> id_ok)
    else $error("Standard identifier compared bits below 18");

  AST_SHORT_PAYLOAD: assert property (
    rx_frame_valid && id_ok && length_ok && rx_low_bytes_match &&
      (rx_length_code <= 4'h4) |=> frame_match ##1 1'b1)
    else $error("Bytes beyond the length blocked a match");

endmodule

// ==== testbench/wfm_frame_source.sv ====
// Behavioural CAN node presenting received wake-up frames to the block
`timescale 1ns/1ns
module wfm_frame_source (
  input wire logic clock,
  output logic rx_frame_valid,
  output logic [28:0] rx_id,
  output logic rx_id_ext,
  output logic [3:0] rx_length_code,
  output logic [31:0] rx_payload,
  output logic rx_low_bytes_match
);
  // Packed frame lines: id, extension, length code, bytes 7..4, low match
  logic [66:0] lines = '0;
  assign {rx_id, rx_id_ext, rx_length_code, rx_payload, rx_low_bytes_match} = lines;
  initial rx_frame_valid = 1'b0;
  // One frame for one cycle; call just after a rising edge
  task automatic send(input logic [66:0] f);
    rx_frame_valid <= 1'b1;
    lines <= f;
    @(posedge clock);
    rx_frame_valid <= 1'b0;
    // Released lines show the inverse so stale data never passes for a frame
    lines <= ~f;
  endtask
endmodule

// ==== testbench/tb_top.sv ====
// Self-checking bench for the wake frame match registers and compare
`timescale 1ns/1ns
module tb_top
  import wfm_pkg::*;
;
  logic clock, resetn, soft_reset, restart, reg_wr, reg_rd, cfg_valid_set, ext_config_changed;
  logic [6:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata;
  logic cfg_id_ext, reg_hit, wake_config_valid, frame_match, wake_detect;
  logic [28:0] cfg_id_value, rx_id;
  logic rx_frame_valid, rx_id_ext, rx_low_bytes_match;
  logic [3:0] rx_length_code;
  logic [31:0] rx_payload;
  logic [7:0] shadow [39:47]; // Expected register contents
  logic exp_valid; // Expected valid flag
  int num_errors = 0;
  int total_checks = 0;
  int cycles = 0;

  wfm_core wfm_core_i (.clock(clock), .resetn(resetn), .soft_reset(soft_reset),
    .restart(restart), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .cfg_valid_set(cfg_valid_set), .ext_config_changed(ext_config_changed),
    .cfg_id_value(cfg_id_value), .cfg_id_ext(cfg_id_ext), .rx_frame_valid(rx_frame_valid),
    .rx_id(rx_id), .rx_id_ext(rx_id_ext), .rx_length_code(rx_length_code),
    .rx_payload_byte_seven(rx_payload[31:24]), .rx_payload_byte_six(rx_payload[23:16]),
    .rx_payload_byte_five(rx_payload[15:8]), .rx_payload_byte_four(rx_payload[7:0]),
    .rx_low_bytes_match(rx_low_bytes_match), .reg_rdata(reg_rdata), .reg_hit(reg_hit),
    .wake_config_valid(wake_config_valid), .frame_match(frame_match),
    .wake_detect(wake_detect));
  wfm_frame_source wfm_frame_source_i (.clock(clock), .rx_frame_valid(rx_frame_valid),
    .rx_id(rx_id), .rx_id_ext(rx_id_ext), .rx_length_code(rx_length_code),
    .rx_payload(rx_payload), .rx_low_bytes_match(rx_low_bytes_match));

  // Free-running 250 MHz clock
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  // Hang guard, far above the few hundred cycles the run needs
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      results();
    end
  end

  task automatic results();
    $display("Checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Byte results
  task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Flag results
  task automatic chk1(input string what, input logic exp, input logic got);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %b seen %b", what, exp, got);
    end
  endtask
  // Bits that exist in each register; reserved ones read zero
  function automatic logic [7:0] keep(input logic [6:0] a);
    if (a == WFM_ADDR_MASK_LOWER) return WFM_MASK_LOWER_KEEP;
    if (a == WFM_ADDR_LENGTH_CODE) return WFM_LENGTH_CODE_KEEP;
    return 8'hff;
  endfunction
  function automatic logic mapped(input logic [6:0] a);
    return a >= WFM_ADDR_MASK_UPPER && a <= WFM_ADDR_PAYLOAD4;
  endfunction
  // Configured bytes 7..4, byte 4 lowest
  function automatic logic [31:0] pl_cfg();
    return {shadow[44], shadow[45], shadow[46], shadow[47]};
  endfunction
  // Expected match from the shadow configuration
  function automatic logic exp_match(input logic [66:0] f);
    logic [28:0] m;
    logic [31:0] bm;
    int len;
    m = {shadow[39], shadow[40], shadow[41], shadow[42][6:2]};
    if (!cfg_id_ext) m = m & WFM_STD_ID_WINDOW;
    len = (f[36:33] > 4'h8) ? 8 : int'(f[36:33]);
    bm = '0;
    for (int k = 4; k < 8; k++) begin
      if (len > k) bm[8*(k-4) +: 8] = 8'hff;
    end
    return (((f[66:38] ^ cfg_id_value) & m) == '0) && (f[37] == cfg_id_ext) &&
      (f[36:33] == shadow[43][3:0]) && (((f[32:1] ^ pl_cfg()) & bm) == '0) && f[0];
  endfunction

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
    if (mapped(a)) begin
      shadow[a] = d & keep(a);
      exp_valid = 1'b0;
    end
    @(posedge clock);
  endtask
  task automatic rd(input logic [6:0] a);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    chk8("reg_rdata", mapped(a) ? shadow[a] : 8'h00, reg_rdata);
    chk1("reg_hit", mapped(a), reg_hit);
    chk1("wake_config_valid", exp_valid, wake_config_valid);
    @(posedge clock);
  endtask
  // Write and read back on the next edge, as the port allows back to back
  task automatic wr_rd(input logic [6:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    shadow[a] = d & keep(a);
    exp_valid = 1'b0;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    chk8("reg_rdata", shadow[a], reg_rdata);
    chk1("reg_hit", 1'b1, reg_hit);
    @(posedge clock);
  endtask
  // Reads one unmapped place on each side of the block too
  task automatic rd_all();
    for (int a = 38; a <= 48; a++) rd(7'(a));
  endtask
  task automatic set_valid();
    cfg_valid_set <= 1'b1;
    @(posedge clock);
    cfg_valid_set <= 1'b0;
    exp_valid = 1'b1;
    #1;
    chk1("wake_config_valid", exp_valid, wake_config_valid);
    @(posedge clock);
  endtask
  // k: 0 soft reset, 1 restart, 2 change elsewhere
  task automatic ctl(input int k);
    {soft_reset, restart, ext_config_changed} <= 3'b100 >> k;
    @(posedge clock);
    {soft_reset, restart, ext_config_changed} <= 3'b000;
    if (k != 1) exp_valid = 1'b0;
    if (k == 0) begin
      foreach (shadow[a]) shadow[a] = 8'h00;
    end
    @(posedge clock);
  endtask
  task automatic frame(input logic [66:0] f);
    logic m, w;
    m = exp_match(f);
    w = m & exp_valid;
    wfm_frame_source_i.send(f);
    #1;
    chk1("frame_match", m, frame_match);
    chk1("wake_detect", w, wake_detect);
    if (w) exp_valid = 1'b0;
    chk1("wake_config_valid", exp_valid, wake_config_valid);
    @(posedge clock);
  endtask
  // Random configuration, written before it is marked valid
  task automatic cfg_random();
    for (int a = 39; a <= 47; a++) wr(7'(a), 8'($urandom));
    cfg_id_value <= 29'($urandom);
    cfg_id_ext <= 1'($urandom);
    @(posedge clock);
    set_valid();
  endtask

  initial begin
    logic [66:0] f;
    resetn = 1'b0;
    {soft_reset, restart, reg_wr, reg_rd, cfg_valid_set, ext_config_changed} = '0;
    {reg_addr, reg_wdata, cfg_id_value, cfg_id_ext} = '0;
    foreach (shadow[a]) shadow[a] = 8'h00;
    exp_valid = 1'b0;
    void'($urandom(96831));
    repeat (20) @(posedge clock);
    resetn <= 1'b1;
    @(posedge clock);
    rd_all();
    // Random bytes into every place, unmapped neighbours included
    repeat (3) begin
      for (int a = 38; a <= 48; a++) wr(7'(a), 8'($urandom));
      rd_all();
      wr_rd(WFM_ADDR_MASK_LOWER, 8'($urandom));
      wr_rd(WFM_ADDR_PAYLOAD7, 8'($urandom));
    end
    set_valid();
    ctl(2);
    rd(WFM_ADDR_MASK_UPPER);
    // Random frames, most built from the configuration with one fault
    for (int n = 0; n < 48; n++) begin
      if (n % 8 == 0) cfg_random();
      f = {cfg_id_value, cfg_id_ext, shadow[43][3:0], pl_cfg(), 1'b1};
      case ($urandom_range(5))
        1: f[38 + $urandom_range(28)] ^= 1'b1;
        2: f[33 + $urandom_range(3)] ^= 1'b1;
        3: f[1 + $urandom_range(31)] ^= 1'b1;
        4: f[0] = 1'b0;
        5: f[37] ^= 1'b1;
        default: ;
      endcase
      frame(f);
    end
    // Every length code: byte 4 differs, then the code with bit 3 flipped
    for (int c = 0; c < 16; c++) begin
      wr(WFM_ADDR_LENGTH_CODE, 8'(c));
      set_valid();
      frame({cfg_id_value, cfg_id_ext, 4'(c), pl_cfg() ^ 32'h000000ff, 1'b1});
      frame({cfg_id_value, cfg_id_ext, 4'(c ^ 8), pl_cfg(), 1'b1});
    end
    // Restart keeps contents; soft and power-on reset clear them
    for (int a = 39; a <= 47; a++) wr(7'(a), 8'hff);
    ctl(1);
    rd_all();
    set_valid();
    ctl(0);
    rd_all();
    cfg_random();
    resetn <= 1'b0;
    @(posedge clock);
    resetn <= 1'b1;
    foreach (shadow[a]) shadow[a] = 8'h00;
    exp_valid = 1'b0;
    @(posedge clock);
    rd_all();
    results();
  end
endmodule
